// [srb_exec.sv]
// Purpose: Executes logical right shifts and byte stores
// Assumes: Register file outside; operands presented with the instruction
// Notes:   One instruction accepted per cycle; results registered
`timescale 1ns/1ns
`default_nettype none
module srb_exec #(
  parameter bit HAS_DCACHE = 1'b1
) (
  // Clock and reset
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  // Instruction and operands
  input  wire logic [31:0] instr_in,
  input  wire logic        valid_in,
  input  wire logic [31:0] src_a_in,
  input  wire logic [31:0] src_b_in,
  // Fault checks on the store address, from the memory unit
  input  wire logic        fault_super_in,
  input  wire logic        fault_perm_in,
  input  wire logic        fault_fast_miss_in,
  input  wire logic        fault_double_miss_in,
  input  wire logic        fault_region_in,
  // Register file write-back
  output logic             wb_en_out,
  output logic [4:0]       wb_idx_out,
  output logic [31:0]      wb_data_out,
  // Register read indices (combinational lookup happens outside)
  output logic [4:0]       rd_idx_a_out,
  output logic [4:0]       rd_idx_b_out,
  // Data bus byte write
  output logic             bus_write_out,
  output logic [31:0]      bus_addr_out,
  output logic [31:0]      bus_wdata_out,
  output logic [3:0]       bus_byteen_out,
  // Cache write port
  output logic             cache_write_out,
  // Exception report
  output logic             exc_out,
  output logic [2:0]       exc_cause_out
);
  srb_dec_if d();
  srb_decode u_dec (
    .instr_in (instr_in),
    .valid_in (valid_in),
    .d        (d)
  );

  logic [31:0] eff_addr;
  logic [2:0]  fault;
  logic        is_store;
  // Effective address with sign-extended offset
  assign eff_addr = src_a_in +
    {{16{d.signed_offset_imm[15]}}, d.signed_offset_imm};
  assign is_store = d.is_stb || d.is_stbio;

  // Fault priority; byte access can never be misaligned
  always_comb begin
    fault = 3'(srb_pkg::SRB_EXC_NONE);
    if (fault_super_in)
      fault = 3'(srb_pkg::SRB_EXC_SUPER);
    else if (fault_fast_miss_in)
      fault = 3'(srb_pkg::SRB_EXC_FAST_MISS);
    else if (fault_double_miss_in)
      fault = 3'(srb_pkg::SRB_EXC_DOUBLE_MISS);
    else if (fault_perm_in)
      fault = 3'(srb_pkg::SRB_EXC_PERM);
    else if (fault_region_in)
      fault = 3'(srb_pkg::SRB_EXC_REGION);
  end

  // Index outputs are registered copies for the register file pipeline
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_idx_a_out <= 5'h00;
      rd_idx_b_out <= 5'h00;
    end else begin
      rd_idx_a_out <= d.idx_a;
      rd_idx_b_out <= d.idx_b;
    end
  end

  // Shift write-back; zero fill from unsigned shift
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      wb_en_out   <= 1'b0;
      wb_idx_out  <= 5'h00;
      wb_data_out <= 32'h00000000;
    end else begin
      wb_en_out  <= d.is_srl || d.is_srli;
      wb_idx_out <= d.idx_c;
      if (d.is_srl)
        wb_data_out <= src_a_in >> src_b_in[4:0];
      else if (d.is_srli)
        wb_data_out <= src_a_in >> d.shift_count_imm;
      else
        wb_data_out <= 32'h00000000;
    end
  end

  // Store issue: cache absorbs plain stores, I/O stores go to the bus
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      bus_write_out   <= 1'b0;
      cache_write_out <= 1'b0;
      bus_addr_out    <= 32'h00000000;
      bus_wdata_out   <= 32'h00000000;
      bus_byteen_out  <= 4'h0;
      exc_out         <= 1'b0;
      exc_cause_out   <= 3'h0;
    end else begin
      exc_out       <= is_store && fault != 3'(srb_pkg::SRB_EXC_NONE);
      exc_cause_out <= is_store ? fault : 3'h0;
      // A faulting store writes nothing
      if (is_store && fault == 3'(srb_pkg::SRB_EXC_NONE)) begin
        bus_write_out   <= d.is_stbio || !HAS_DCACHE;
        cache_write_out <= d.is_stb && HAS_DCACHE;
        bus_addr_out    <= eff_addr;
        // Byte replicated on all lanes, one lane enabled
        bus_wdata_out   <= {4{src_b_in[7:0]}};
        bus_byteen_out  <= 4'h1 << eff_addr[1:0];
      end else begin
        bus_write_out   <= 1'b0;
        cache_write_out <= 1'b0;
        bus_byteen_out  <= 4'h0;
      end
    end
  end

  // Shift results and decode, checked one cycle after the taking edge
  a_srl_result: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    d.is_srl |=> wb_en_out &&
      wb_data_out == ($past(src_a_in) >> $past(src_b_in[4:0])))
    else $error("register shift result wrong");
  a_srl_decode: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    (valid_in && instr_in[5:0] == 6'h3A && instr_in[16:11] == 6'h1B &&
     instr_in[10:6] != 5'h00) |=> !wb_en_out)
    else $error("shift with nonzero field accepted");
  a_srli_result: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    d.is_srli |=> wb_data_out ==
      ($past(src_a_in) >> $past(instr_in[10:6])))
    else $error("immediate shift result wrong");
  a_srli_decode: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    (valid_in && instr_in[5:0] == 6'h3A && instr_in[16:11] == 6'h1A)
      |=> wb_en_out && wb_idx_out == $past(instr_in[21:17]))
    else $error("immediate shift not decoded");
  // Shifts never reach the data side and raise no exception
  a_shift_quiet: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    (d.is_srl || d.is_srli) |=> !bus_write_out && !cache_write_out &&
      !exc_out)
    else $error("shift disturbed the data side");
  // A word without valid must leave every pulse output low
  a_idle_quiet: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    !valid_in |=> !wb_en_out && !bus_write_out && !cache_write_out &&
      !exc_out)
    else $error("output pulse without a valid word");

  // Store address, byte and lane; the lane follows the low address bits
  a_store_addr: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    bus_write_out |-> bus_addr_out == $past(src_a_in) +
      {{16{$past(instr_in[21])}}, $past(instr_in[21:6])})
    else $error("store address wrong");
  a_store_byte: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    bus_write_out |-> $onehot(bus_byteen_out) &&
      bus_wdata_out[7:0] == $past(src_b_in[7:0]))
    else $error("store not a single byte");
  a_lane_match: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    (bus_write_out || cache_write_out) |->
      bus_byteen_out == 4'h1 << bus_addr_out[1:0])
    else $error("byte lane does not match address");
  a_lanes_idle: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    !(bus_write_out || cache_write_out) |-> bus_byteen_out == 4'h0)
    else $error("byte lane enabled without a store");
  a_stb_cached: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    (HAS_DCACHE && d.is_stb && fault == 3'h0) |=>
      cache_write_out && !bus_write_out)
    else $error("cacheable store misrouted");
  a_stbio_bus: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    (d.is_stbio && fault == 3'h0) |=> bus_write_out && !cache_write_out)
    else $error("io store missed the bus");
  a_nocache_same: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    (!HAS_DCACHE && is_store && fault == 3'h0) |=> bus_write_out)
    else $error("store without cache not on bus");
  a_store_opcodes: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    (valid_in && (instr_in[5:0] == 6'h05 || instr_in[5:0] == 6'h25) &&
     fault == 3'h0) |=> (bus_write_out || cache_write_out))
    else $error("byte store opcode ignored");

  // Any fault blocks the write; the cause code stands only with it
  a_fault_blocks: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    (is_store && (fault_super_in || fault_perm_in || fault_fast_miss_in ||
     fault_double_miss_in || fault_region_in)) |=> exc_out &&
      !bus_write_out && !cache_write_out)
    else $error("faulting store wrote");
  a_fault_order: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    (is_store && fault_super_in) |=>
      exc_cause_out == 3'(srb_pkg::SRB_EXC_SUPER))
    else $error("supervisor fault not reported first");
  a_cause_idle: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    !exc_out |-> exc_cause_out == 3'(srb_pkg::SRB_EXC_NONE))
    else $error("cause code without an exception");

  c_srl: cover property (@(posedge mclk_in) disable iff (rst_in) d.is_srl);
  c_srli: cover property (@(posedge mclk_in) disable iff (rst_in)
    d.is_srli ##1 d.is_srli);
  c_stbio: cover property (@(posedge mclk_in) disable iff (rst_in)
    bus_write_out && bus_byteen_out == 4'h8);
  c_exc: cover property (@(posedge mclk_in) disable iff (rst_in) exc_out);
  c_stb_then_io: cover property (@(posedge mclk_in) disable iff (rst_in)
    cache_write_out ##1 bus_write_out);
endmodule // srb_exec
`default_nettype wire

// [srb_pkg.sv]
// Purpose: Shared constants for the shift-right and byte-store unit
// Assumes: 32-bit instruction words, R-type and I-type field layout
// Notes:   Field positions, opcodes and cause codes are the only numbers used elsewhere
`default_nettype none
package srb_pkg;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned REG_IDX_W  = 5;
  // Field positions of the instruction word
  localparam int unsigned FLD_A_LSB  = 27;
  localparam int unsigned FLD_B_LSB  = 22;
  localparam int unsigned FLD_C_LSB  = 17;
  localparam int unsigned FLD_X_LSB  = 11;
  localparam int unsigned FLD_SH_LSB = 6;
  localparam int unsigned FLD_OP_LSB = 0;
  localparam int unsigned FLD_I16_LSB = 6;
  // Opcodes
  localparam logic [5:0] OP_RTYPE    = 6'h3A;
  localparam logic [5:0] OPX_SRL     = 6'h1B;
  localparam logic [5:0] OPX_SRLI    = 6'h1A;
  localparam logic [5:0] OP_STB      = 6'h05;
  localparam logic [5:0] OP_STBIO    = 6'h25;
  // Exception cause codes reported with a refused store
  typedef enum logic [2:0] {
    SRB_EXC_NONE, SRB_EXC_SUPER, SRB_EXC_MISALIGN, SRB_EXC_PERM,
    SRB_EXC_FAST_MISS, SRB_EXC_DOUBLE_MISS, SRB_EXC_REGION
  } srb_exc_e;
endpackage
`default_nettype wire

// [srb_dec_if.sv]
// Purpose: Decoded instruction fields passed from decoder to executor
// Assumes: Single clock, decoder is purely combinational
// Notes:   One modport for each side
`timescale 1ns/1ns
`default_nettype none
interface srb_dec_if;
  logic                is_srl;
  logic                is_srli;
  logic                is_stb;
  logic                is_stbio;
  logic [4:0]          idx_a;
  logic [4:0]          idx_b;
  logic [4:0]          idx_c;
  logic [4:0]          shift_count_imm;
  logic [15:0]         signed_offset_imm;
  modport dec (output is_srl, is_srli, is_stb, is_stbio, idx_a, idx_b,
               idx_c, shift_count_imm, signed_offset_imm);
  modport exe (input is_srl, is_srli, is_stb, is_stbio, idx_a, idx_b,
               idx_c, shift_count_imm, signed_offset_imm);
endinterface
`default_nettype wire

// [srb_decode.sv]
// Purpose: Instruction decoder for logical right shifts and byte stores
// Assumes: Instruction word is stable while valid
// Notes:   Purely combinational; unknown words decode to nothing
`timescale 1ns/1ns
`default_nettype none
module srb_decode (
  // Instruction
  input  wire logic [31:0] instr_in,
  input  wire logic        valid_in,
  // Decoded fields
  srb_dec_if.dec           d
);
  logic [5:0] op;
  logic [5:0] opx;
  assign op  = instr_in[srb_pkg::FLD_OP_LSB +: 6];
  assign opx = instr_in[srb_pkg::FLD_X_LSB +: 6];
  // R-type decode; register form needs a zero shift field
  assign d.is_srl   = valid_in && op == srb_pkg::OP_RTYPE &&
                      opx == srb_pkg::OPX_SRL &&
                      instr_in[srb_pkg::FLD_SH_LSB +: 5] == 5'h00;
  assign d.is_srli  = valid_in && op == srb_pkg::OP_RTYPE &&
                      opx == srb_pkg::OPX_SRLI;
  // I-type byte stores
  assign d.is_stb   = valid_in && op == srb_pkg::OP_STB;
  assign d.is_stbio = valid_in && op == srb_pkg::OP_STBIO;
  // Register index fields, upper three 5-bit slots
  assign d.idx_a = instr_in[srb_pkg::FLD_A_LSB +: 5];
  assign d.idx_b = instr_in[srb_pkg::FLD_B_LSB +: 5];
  assign d.idx_c = instr_in[srb_pkg::FLD_C_LSB +: 5];
  assign d.shift_count_imm   = instr_in[srb_pkg::FLD_SH_LSB +: 5];
  assign d.signed_offset_imm = instr_in[srb_pkg::FLD_I16_LSB +: 16];
endmodule // srb_decode
`default_nettype wire

// [srb_mem_model.sv]
// Purpose: Byte-wide data memory standing on the far side of the data bus
// Assumes: One byte lane enabled per write, as the store unit issues
// Notes:   Only 64 bytes are kept, so addresses alias above that range
`timescale 1ns/1ns
`default_nettype none
module srb_mem_model (
  // Clock
  input  wire logic        mclk_in,
  // Data bus write
  input  wire logic        bus_write_in,
  input  wire logic [31:0] bus_addr_in,
  input  wire logic [31:0] bus_wdata_in,
  input  wire logic [3:0]  bus_byteen_in,
  // Read-back for the bench
  input  wire logic [5:0]  rd_addr_in,
  output logic      [7:0]  rd_data_out
);
  logic [7:0] mem [64];
  // Store only the enabled lane; neighbours keep their old contents
  always_ff @(posedge mclk_in) begin
    for (int l = 0; l < 4; l++) begin
      if (bus_write_in && bus_byteen_in[l]) begin
        mem[bus_addr_in[5:0]] <= bus_wdata_in[8*l +: 8];
      end
    end
  end
  assign rd_data_out = mem[rd_addr_in];
endmodule // srb_mem_model
`default_nettype wire

// [srb_exec_tb.sv]
// Purpose: Self-checking bench for the shift-right and byte-store unit
// Assumes: Main copy has a data cache, a second copy has none
// Notes:   Driver queues expected results, monitor compares in order
`timescale 1ns/1ns
`default_nettype none
module srb_exec_tb;
  logic        mclk_in, rst_in, valid, wb_en, bus_wr, cache_wr, exc;
  logic [31:0] instr, sa, sb, addr, wdata, wb_data, a, b, c, ea, rng;
  logic [4:0]  flt, wb_idx, k, rda, rdb;
  logic        nc_bw, nc_cw;
  logic [31:0] nc_addr, nc_wdata;
  logic [3:0]  nc_be;
  logic [3:0]  be;
  logic [2:0]  cause;
  logic [5:0]  rd_addr;
  logic [7:0]  mem_rd;
  logic [71:0] got, got_nc;
  logic [71:0] exp_q[$], exp_nc[$];
  logic [2:0]  cz [6];
  int          n_fail, n_tests, cyc;

  srb_exec i_srb_exec (.mclk_in(mclk_in), .rst_in(rst_in),
    .instr_in(instr), .valid_in(valid), .src_a_in(sa), .src_b_in(sb),
    .fault_super_in(flt[0]), .fault_perm_in(flt[1]),
    .fault_fast_miss_in(flt[2]), .fault_double_miss_in(flt[3]),
    .fault_region_in(flt[4]), .wb_en_out(wb_en), .wb_idx_out(wb_idx),
    .wb_data_out(wb_data), .rd_idx_a_out(rda), .rd_idx_b_out(rdb),
    .bus_write_out(bus_wr), .bus_addr_out(addr), .bus_wdata_out(wdata),
    .bus_byteen_out(be), .cache_write_out(cache_wr), .exc_out(exc),
    .exc_cause_out(cause));
  srb_mem_model i_srb_mem_model (.mclk_in(mclk_in), .bus_write_in(bus_wr),
    .bus_addr_in(addr), .bus_wdata_in(wdata), .bus_byteen_in(be),
    .rd_addr_in(rd_addr), .rd_data_out(mem_rd));
  // Cacheless copy on the same stimulus: every fault-free store must reach the bus
  srb_exec #(.HAS_DCACHE(1'b0)) i_srb_exec_nc (.mclk_in(mclk_in),
    .rst_in(rst_in), .instr_in(instr), .valid_in(valid), .src_a_in(sa),
    .src_b_in(sb), .fault_super_in(flt[0]), .fault_perm_in(flt[1]),
    .fault_fast_miss_in(flt[2]), .fault_double_miss_in(flt[3]),
    .fault_region_in(flt[4]), .wb_en_out(), .wb_idx_out(),
    .wb_data_out(), .rd_idx_a_out(), .rd_idx_b_out(),
    .bus_write_out(nc_bw), .bus_addr_out(nc_addr),
    .bus_wdata_out(nc_wdata), .bus_byteen_out(nc_be),
    .cache_write_out(nc_cw), .exc_out(), .exc_cause_out());

  always #25 mclk_in = ~mclk_in;

  function automatic logic [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  task automatic check(input logic [71:0] g, input logic [71:0] e);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic test_done();
    if (n_fail == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Requests change just after an edge and are taken at the next one
  task automatic issue(input logic [31:0] w, x, y, input logic [4:0] f);
    @(posedge mclk_in);
    instr <= w;
    valid <= 1'b1;
    sa    <= x;
    sb    <= y;
    flt   <= f;
  endtask

  // Hang guard: the whole run needs well under a hundred cycles
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 500) begin
      n_fail++;
      test_done();
    end
  end

  // Monitor: any result pulse takes the oldest note off the queue
  always @(negedge mclk_in) begin
    if (!rst_in && (wb_en || bus_wr || cache_wr || exc)) begin
      got = {wb_en, bus_wr, cache_wr, exc, 68'h0};
      if (wb_en) got[63:0] = {17'h0, rda, rdb, wb_idx, wb_data};
      else if (bus_wr || cache_wr) got[67:0] = {be, addr, wdata};
      else if (exc) got[63:0] = {61'h0, cause};
      check(got, exp_q.size() ? exp_q.pop_front() : 72'h0);
    end
  end

  // Monitor of the cacheless copy; a cache pulse there is a mismatch
  always @(negedge mclk_in) begin
    if (!rst_in && (nc_bw || nc_cw)) begin
      got_nc = {3'h0, nc_cw, nc_be, nc_addr, nc_wdata};
      check(got_nc, exp_nc.size() ? exp_nc.pop_front() : 72'h0);
    end
  end

  initial begin
    cz = '{srb_pkg::SRB_EXC_SUPER, srb_pkg::SRB_EXC_PERM,
           srb_pkg::SRB_EXC_FAST_MISS, srb_pkg::SRB_EXC_DOUBLE_MISS,
           srb_pkg::SRB_EXC_REGION, srb_pkg::SRB_EXC_SUPER};
    {mclk_in, valid, sa, sb, flt, rd_addr, n_fail, n_tests, cyc} = '0;
    rst_in = 1'b1;
    instr  = 32'h0;
    rng    = 32'h0000_000E;
    repeat (3) @(posedge mclk_in);
    rst_in <= 1'b0;
    // Shifts back to back, counts 0 and 31 included, B upper bits random
    for (int i = 0; i < 16; i++) begin
      a = rnd();
      b = rnd();
      c = rnd();
      k = (i % 8 == 0) ? 5'h00 : (i % 8 == 1) ? 5'h1F : c[19:15];
      if (i < 8) b[4:0] = k;
      exp_q.push_back({8'h80, 17'h0, c[9:5], c[14:10],
                       c[4:0], a >> k});
      issue({c[9:5], c[14:10], c[4:0],
             (i < 8) ? srb_pkg::OPX_SRL : srb_pkg::OPX_SRLI,
             (i < 8) ? 5'h00 : k, srb_pkg::OP_RTYPE}, a, b, 5'h0);
    end
    // Refused: nonzero immediate field on srl, unknown opcode, valid low
    issue({15'h1234, srb_pkg::OPX_SRL, 5'h01, srb_pkg::OP_RTYPE}, a, b,
          5'h0);
    issue(32'h0000_003F, a, b, 5'h0);
    @(posedge mclk_in);
    valid <= 1'b0;
    instr <= {c[9:5], c[14:10], c[4:0], srb_pkg::OPX_SRLI, 5'h03,
              srb_pkg::OP_RTYPE};
    // Byte stores, cacheable and I/O alternating, offsets of both signs
    for (int i = 0; i < 12; i++) begin
      a  = rnd();
      b  = rnd();
      c  = rnd();
      ea = a + {{16{c[15]}}, c[15:0]};
      exp_q.push_back({(i % 2) ? 4'h4 : 4'h2, 4'h1 << ea[1:0], ea,
                       {4{b[7:0]}}});
      exp_nc.push_back({4'h0, 4'h1 << ea[1:0], ea, {4{b[7:0]}}});
      issue({c[20:16], c[25:21], c[15:0], (i % 2) ? srb_pkg::OP_STBIO
             : srb_pkg::OP_STB}, a, b, 5'h0);
    end
    // Faulting stores: each fault alone, then all at once
    for (int i = 0; i < 6; i++) begin
      exp_q.push_back({4'h1, 65'h0, cz[i]});
      issue({10'h155, 16'h8000, (i % 2) ? srb_pkg::OP_STBIO
             : srb_pkg::OP_STB}, rnd(), rnd(),
            (i == 5) ? 5'h1F : 5'h01 << i);
    end
    @(posedge mclk_in);
    valid   <= 1'b0;
    flt     <= 5'h0;
    rd_addr <= ea[5:0];
    repeat (4) @(posedge mclk_in);
    check({64'h0, mem_rd}, {64'h0, b[7:0]});
    check(72'(exp_q.size()), 72'h0);
    check(72'(exp_nc.size()), 72'h0);
    test_done();
  end
endmodule // srb_exec_tb
`default_nettype wire
